// ### pkg/aspc_pkg.sv
// Shared constants and types for the audio serial port block.
// Assumes one APB slave on pclk and a link domain on the input bit clock.
`default_nettype none

package aspc_pkg;

  // APB register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_TXL = 8'h08;
  localparam logic [7:0] A_TXR = 8'h0C;
  localparam logic [7:0] A_RXL = 8'h10;
  localparam logic [7:0] A_RXR = 8'h14;
  localparam logic [7:0] A_THR = 8'h18;

  // Control field positions and reset values
  localparam int CTRL_TXEN = 0;
  localparam int CTRL_MIC = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] THR_RST = 16'h0100;

  // 384 fs ticks per output bit, output bits per frame
  localparam logic [3:0] SUB_48 = 4'h8;
  localparam logic [3:0] SUB_64 = 4'h6;
  localparam logic [6:0] BITS_48 = 7'h30;
  localparam logic [6:0] BITS_64 = 7'h40;
  localparam logic [6:0] SMP_BITS = 7'h10;
  localparam logic [3:0] MSB_IDX = 4'hF;

  // Receiver bit counter marks
  localparam logic [4:0] FWD_LAST = 5'h0F;
  localparam logic [4:0] CNT_MAX = 5'h1F;

  typedef struct packed {
    logic right;
    logic [15:0] data;
  } aspc_smp_t;

  typedef struct packed {
    logic xtal;
    logic ext;
    logic src;
    logic align;
    logic rate;
    logic mode_a;
    logic mode_b;
    logic rx_tgl;
  } aspc_pins_t;

  typedef struct packed {
    logic music;
    logic mic;
    logic src;
    logic align;
    logic rate;
    logic mode_a;
    logic mode_b;
  } aspc_stat_t;

endpackage : aspc_pkg

`default_nettype wire

// ### verilog/aspc_sync2.sv
// Two-flop level synchroniser, any width.
// Assumes each bit is an independent level or a slow toggle.
`default_nettype none

module aspc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);

  logic [W-1:0] m_q;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      m_q <= '0;
      q <= '0;
    end
    else
    begin
      m_q <= d;
      q <= m_q;
    end

endmodule : aspc_sync2

`default_nettype wire

// ### verilog/aspc_rx.sv
// Serial audio receiver, runs on the incoming bit clock.
// Assumes data and word clock change on the falling bit clock edge.
`default_nettype none

module aspc_rx
  import aspc_pkg::*;
(
  input wire logic bclk, // incoming bit clock
  input wire logic rst_n, // reset, release synced
  input wire logic sdata, // serial data pin
  input wire logic lrck, // word clock pin, high is left
  input wire logic align_fwd, // high: forward packed
  output aspc_smp_t smp_q, // last captured sample
  output logic tgl_q // flips once per sample
);

  logic [15:0] sh_q;
  logic lr_q;
  logic [4:0] cnt_q;
  logic arm_q;

  // First edge out of reset only learns the word clock level, no false edge
  wire lr_edge = arm_q && lrck != lr_q;
  wire [15:0] sh_d = {sh_q[14:0], sdata};
  // Backward: the half just closed left its last 16 bits behind
  wire cap_back = lr_edge && !align_fwd;
  wire cap_fwd = align_fwd && !lr_edge && cnt_q == FWD_LAST;
  wire [4:0] cnt_inc = cnt_q + 5'h01;
  wire [4:0] cnt_d = lr_edge ? 5'h01 : (cnt_q == CNT_MAX ? CNT_MAX : cnt_inc);

  always_ff @(posedge bclk or negedge rst_n)
    if (!rst_n)
    begin
      sh_q <= 16'h0000;
      lr_q <= 1'b0;
      cnt_q <= 5'h00;
      arm_q <= 1'b0;
      smp_q <= '0;
      tgl_q <= 1'b0;
    end
    else
    begin
      lr_q <= lrck;
      arm_q <= 1'b1;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      if (cap_back)
        smp_q <= {!lr_q, sh_q};
      else if (cap_fwd)
        smp_q <= {!lrck, sh_d};
      tgl_q <= tgl_q ^ (cap_back || cap_fwd);
    end

  back_capture_a:
  assert property (@(posedge bclk) disable iff (!rst_n)
    cap_back |=> smp_q.data == $past(sh_q) && tgl_q != $past(tgl_q))
  else $error("backward packed word not captured");

  fwd_capture_a:
  assert property (@(posedge bclk) disable iff (!rst_n)
    cap_fwd |=> smp_q.data == $past(sh_d) && smp_q.right == !$past(lrck))
  else $error("forward packed word not captured");

endmodule : aspc_rx

`default_nettype wire

// ### verilog/aspc_top.sv
// Audio serial ports: clock source, serial in and out, signal indicators.
// Assumes APB on pclk; input bit clock is an unrelated link clock.
`default_nettype none

module aspc_top
  import aspc_pkg::*;
(
  input wire logic pclk, // APB and audio clock
  input wire logic presetn, // async reset, active low
  input wire logic [7:0] paddr, // APB byte address
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic crystal_in, // 768 fs oscillator level
  output logic crystal_out, // oscillator feedback
  input wire logic ext_half_master_clk_in, // external 384 fs clock
  input wire logic clk_source_select, // high: use external 384 fs
  input wire logic input_align_select, // high: forward packed input
  input wire logic output_bitrate_select, // high: 64 fs out
  input wire logic init_mode_sel_a, // mode strap a
  input wire logic init_mode_sel_b, // mode strap b
  input wire logic in_bit_clk, // input bit clock, link domain
  input wire logic in_word_clk, // input word clock
  input wire logic serial_audio_in, // input serial data
  output logic out_bit_clk, // output bit clock
  output logic out_word_clk, // output word clock, high is left
  output logic serial_audio_out, // output serial data
  output logic mic_present_n, // low while mic present
  output logic music_present_n // low while music present
);

  // Pin synchronisers
  aspc_pins_t pin_raw;
  aspc_pins_t pin_s;
  aspc_smp_t rx_smp;
  logic rx_tgl;
  logic [1:0] lk_s;

  assign pin_raw = {crystal_in, ext_half_master_clk_in, clk_source_select,
                    input_align_select, output_bitrate_select,
                    init_mode_sel_a, init_mode_sel_b, rx_tgl};

  aspc_sync2 #(
    .W(8)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pin_raw),
    .q(pin_s)
  );

  // Link domain: reset release and align strap cross onto the bit clock
  aspc_sync2 #(
    .W(2)
  ) u_lk_sync (
    .clk(in_bit_clk),
    .rst_n(presetn),
    .d({1'b1, input_align_select}),
    .q(lk_s)
  );

  aspc_rx u_rx (
    .bclk(in_bit_clk),
    .rst_n(lk_s[1]),
    .sdata(serial_audio_in),
    .lrck(in_word_clk),
    .align_fwd(lk_s[0]),
    .smp_q(rx_smp),
    .tgl_q(rx_tgl)
  );

  // Clock source selection
  logic xtal_prev_q;
  logic ext_prev_q;
  logic xtal_half_q;
  logic crystal_out_q;

  wire src_ext = pin_s.src;
  wire pin_rate = pin_s.rate;
  wire xtal_rise = pin_s.xtal && !xtal_prev_q;
  // External clock already runs at 384 fs, one tick per rise
  wire ext_rise = pin_s.ext && !ext_prev_q;
  wire tick = src_ext ? ext_rise : (xtal_rise && xtal_half_q);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      xtal_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      xtal_half_q <= 1'b0;
      crystal_out_q <= 1'b1;
    end
    else
    begin
      xtal_prev_q <= pin_s.xtal;
      ext_prev_q <= pin_s.ext;
      if (xtal_rise)
        xtal_half_q <= !xtal_half_q;
      crystal_out_q <= !pin_s.xtal;
    end

  assign crystal_out = crystal_out_q;

  // APB register file
  logic [1:0] ctrl_q;
  logic [15:0] tx_l_q;
  logic [15:0] tx_r_q;
  logic [15:0] rx_l_q;
  logic [15:0] rx_r_q;
  logic [15:0] thr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic mic_n_q;
  logic music_n_q;
  aspc_stat_t stat_w;

  wire setup = psel && !penable;
  wire wr = psel && penable && pready_q && pwrite;
  wire sel_ctrl = paddr == A_CTRL;
  wire sel_stat = paddr == A_STAT;
  wire sel_txl = paddr == A_TXL;
  wire sel_txr = paddr == A_TXR;
  wire sel_rxl = paddr == A_RXL;
  wire sel_rxr = paddr == A_RXR;
  wire sel_thr = paddr == A_THR;
  wire hit = sel_ctrl || sel_stat || sel_txl || sel_txr || sel_rxl || sel_rxr || sel_thr;

  assign stat_w = {!music_n_q, !mic_n_q, pin_s.src, pin_s.align,
                   pin_s.rate, pin_s.mode_a, pin_s.mode_b};

  wire [31:0] rdata_w = sel_ctrl ? {30'h0, ctrl_q} :
                        sel_stat ? {25'h0, stat_w} :
                        sel_txl ? {16'h0, tx_l_q} :
                        sel_txr ? {16'h0, tx_r_q} :
                        sel_rxl ? {16'h0, rx_l_q} :
                        sel_rxr ? {16'h0, rx_r_q} :
                        sel_thr ? {16'h0, thr_q} : 32'h0;

  // One wait-free access cycle; read data is fixed during setup
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= pwrite ? 32'h0 : rdata_w;
        pslverr_q <= !hit;
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      tx_l_q <= 16'h0000;
      tx_r_q <= 16'h0000;
      thr_q <= THR_RST;
    end
    else if (wr)
    begin
      if (sel_ctrl)
        ctrl_q <= pwdata[1:0];
      if (sel_txl)
        tx_l_q <= pwdata[15:0];
      if (sel_txr)
        tx_r_q <= pwdata[15:0];
      if (sel_thr)
        thr_q <= pwdata[15:0];
    end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Received samples; data is held steady for 16 bit clocks after the toggle,
  // far longer than the synchroniser delay, so it is read without its own sync
  logic tgl_prev_q;

  wire rx_new = pin_s.rx_tgl != tgl_prev_q;
  wire [15:0] rx_data = rx_smp.data;
  wire [15:0] rx_neg = 16'h0000 - rx_data;
  wire [15:0] rx_mag = rx_data[15] ? rx_neg : rx_data;
  wire loud = rx_mag > thr_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tgl_prev_q <= 1'b0;
      rx_l_q <= 16'h0000;
      rx_r_q <= 16'h0000;
      music_n_q <= 1'b1;
      mic_n_q <= 1'b1;
    end
    else
    begin
      tgl_prev_q <= pin_s.rx_tgl;
      if (rx_new && rx_smp.right)
        rx_r_q <= rx_data;
      if (rx_new && !rx_smp.right)
        rx_l_q <= rx_data;
      if (rx_new)
        music_n_q <= !loud;
      mic_n_q <= !ctrl_q[CTRL_MIC];
    end

  assign mic_present_n = mic_n_q;
  assign music_present_n = music_n_q;

  // Output serialiser; rate and samples change only at frame boundaries
  logic [3:0] sub_q;
  logic [6:0] bit_q;
  logic rate64_q;
  logic [15:0] txl_q;
  logic [15:0] txr_q;
  logic bck_q;
  logic wck_q;
  logic sdo_q;

  wire [3:0] sub_len = rate64_q ? SUB_64 : SUB_48;
  wire sub_last = sub_q == sub_len - 4'h1;
  wire [6:0] bit_len = rate64_q ? BITS_64 : BITS_48;
  wire bit_last = bit_q == bit_len - 7'h01;
  wire bit_step = tick && sub_last;
  wire frame_end = bit_step && bit_last;
  wire [6:0] half = {1'b0, bit_len[6:1]};
  wire is_left = bit_q < half;
  wire [6:0] pos = is_left ? bit_q : bit_q - half;
  wire [6:0] lead = half - SMP_BITS;
  wire in_win = pos >= lead;
  wire [6:0] off = pos - lead;
  wire [3:0] idx = MSB_IDX - off[3:0];
  wire [15:0] cur = is_left ? txl_q : txr_q;
  wire cur_msb = cur[15];
  wire data_w = in_win && cur[idx];
  wire bck_w = sub_q >= {1'b0, sub_len[3:1]};
  wire txen = ctrl_q[CTRL_TXEN];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sub_q <= 4'h0;
      bit_q <= 7'h00;
    end
    else
    begin
      if (tick)
        sub_q <= sub_last ? 4'h0 : sub_q + 4'h1;
      if (bit_step)
        bit_q <= bit_last ? 7'h00 : bit_q + 7'h01;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rate64_q <= 1'b0;
      txl_q <= 16'h0000;
      txr_q <= 16'h0000;
    end
    else if (frame_end)
    begin
      rate64_q <= pin_rate;
      txl_q <= txen ? tx_l_q : 16'h0000;
      txr_q <= txen ? tx_r_q : 16'h0000;
    end

  // Word clock and data move with the falling bit clock edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bck_q <= 1'b0;
      wck_q <= 1'b1;
      sdo_q <= 1'b0;
    end
    else
    begin
      bck_q <= bck_w;
      wck_q <= is_left;
      sdo_q <= data_w;
    end

  assign out_bit_clk = bck_q;
  assign out_word_clk = wck_q;
  assign serial_audio_out = sdo_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  apb_ready_a:
  assert property (setup |=> pready_q && pslverr_q == !$past(hit))
  else $error("apb answer missing after setup");

  src_select_a:
  assert property (src_ext && tick |->
    $past(ext_half_master_clk_in, 2) && !$past(ext_half_master_clk_in, 3))
  else $error("tick without external clock edge");

  xtal_half_a:
  assert property (!src_ext && tick |=> !xtal_half_q && !tick)
  else $error("crystal not halved to 384 fs");

  frame_len_a:
  assert property (bit_q < bit_len && sub_q < sub_len)
  else $error("bit counter beyond frame length");

  rate_latch_a:
  assert property (frame_end |=> bit_q == 7'h00 && rate64_q == $past(pin_rate))
  else $error("rate not latched at frame end");

  word_edge_a:
  assert property ($changed(wck_q) |-> !bck_q && $past(bck_q))
  else $error("word clock moved off falling bit clock");

  data_window_a:
  assert property (sdo_q |-> $past(in_win))
  else $error("data outside backward packed window");

  msb_first_a:
  assert property (in_win && off == 7'h00 |=> sdo_q == $past(cur_msb))
  else $error("first data bit is not the MSB");

  mic_flag_a:
  assert property ($rose(ctrl_q[CTRL_MIC]) |=> !mic_present_n ##1 !mic_present_n)
  else $error("mic indicator not low");

  music_flag_a:
  assert property (rx_new && loud |=> !music_present_n)
  else $error("music indicator not low");

endmodule : aspc_top

`default_nettype wire

// ### verification/aspc_src.sv
// Model of the audio source and the clock parts in front of the port block.
// Assumes the bench calls send_frame and drives crystal_run.
`default_nettype none

module aspc_src (
  input wire logic crystal_run, // low stops the crystal
  output logic crystal_in, // 768 fs oscillator
  output logic ext_half_master_clk_in, // external 384 fs clock
  output logic in_bit_clk, // link bit clock
  output logic in_word_clk, // word clock, high is left
  output logic serial_audio_in // serial data
);
  timeunit 1ns;
  timeprecision 100ps;

  // Odd offsets keep every edge away from the pclk edges
  initial
  begin
    crystal_in = 1'b0;
    in_bit_clk = 1'b0;
    in_word_clk = 1'b0;
    serial_audio_in = 1'b0;
    #3;
    forever #40 if (crystal_run) crystal_in = ~crystal_in;
  end

  initial
  begin
    ext_half_master_clk_in = 1'b0;
    #7;
    forever #80 ext_half_master_clk_in = ~ext_half_master_clk_in;
  end

  // Bit clock runs only inside the frame and stands still after it
  task automatic send_frame(input logic [15:0] l, input logic [15:0] r, input logic fwd);
    logic [15:0] w;
    int pos;
    #7;
    for (int h = 0; h < 2; h++)
    begin
      w = (h == 0) ? l : r;
      for (int b = 0; b < 32; b++)
      begin
        in_word_clk = (h == 0);
        pos = fwd ? b : b - 16;
        if (pos >= 0 && pos < 16)
          serial_audio_in = w[15 - pos];
        else
          serial_audio_in = b[0];
        #80 in_bit_clk = 1'b1;
        #80 in_bit_clk = 1'b0;
      end
    end
    serial_audio_in = ~serial_audio_in;
  endtask : send_frame
endmodule : aspc_src

`default_nettype wire

// ### verification/aspc_top_tb.sv
// Self-checking bench for the audio serial port block.
// Assumes aspc_src models the source; output frames are judged here.
`default_nettype none

module aspc_top_tb
  import aspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk, presetn, psel, penable, pwrite, src_sel, align_sel, rate_sel, xrun;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, xtal, ext, ibc, iwc, sdi, xout, obc, owc, sdo, mic_n, music_n;
  int fail_count, check_count, cyc;

  aspc_src u_aspc_src (.crystal_run(xrun), .crystal_in(xtal), .ext_half_master_clk_in(ext),
    .in_bit_clk(ibc), .in_word_clk(iwc), .serial_audio_in(sdi));

  aspc_top u_aspc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_in(xtal), .crystal_out(xout), .ext_half_master_clk_in(ext),
    .clk_source_select(src_sel), .input_align_select(align_sel),
    .output_bitrate_select(rate_sel), .init_mode_sel_a(1'b1), .init_mode_sel_b(1'b1),
    .in_bit_clk(ibc), .in_word_clk(iwc), .serial_audio_in(sdi), .out_bit_clk(obc),
    .out_word_clk(owc), .serial_audio_out(sdo), .mic_present_n(mic_n),
    .music_present_n(music_n));

  always #5 pclk = ~pclk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Extra idle edge at the end so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends on pready; only the bench timeout ends it if pready never comes
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(d, exp, "read data");
    chk({31'h0, e}, {31'h0, eexp}, "slave error");
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, v, d, e);
  endtask : wr

  // One output frame, left half first; p is the first bit period
  task automatic grab(output logic [31:0] l, r, nl, nr, p);
    time t0;
    l = 0;
    r = 0;
    nl = 0;
    nr = 0;
    t0 = 0;
    @(posedge owc);
    for (int k = 0; k < 200; k++)
    begin
      @(posedge obc);
      if (k == 0)
        t0 = $time;
      if (k == 1)
        p = 32'($time - t0);
      if (owc === 1'b1 && nr > 0)
        break;
      if (owc === 1'b1)
      begin
        l = {l[30:0], sdo};
        nl++;
      end
      else
      begin
        r = {r[30:0], sdo};
        nr++;
      end
    end
  endtask : grab

  task automatic t_reg();
    chk({31'h0, mic_n}, 32'h1, "mic idle");
    chk({31'h0, music_n}, 32'h1, "music idle");
    rd(A_THR, 32'h0100, 1'b0);
    wr(A_THR, 32'h20);
    rd(A_THR, 32'h20, 1'b0);
    rd(A_STAT, 32'h03, 1'b0);
    rd(8'hFC, 32'h0, 1'b1);
    wr(A_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, mic_n}, 32'h0, "mic present");
    wr(A_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, mic_n}, 32'h1, "mic absent");
    $display("test registers done");
  endtask : t_reg

  task automatic t_rx(input logic fwd, input logic [15:0] v, input logic exp_n);
    align_sel <= fwd;
    repeat (4) @(posedge pclk);
    u_aspc_src.send_frame(v, ~v, fwd);
    u_aspc_src.send_frame(v, ~v, fwd);
    repeat (20) @(posedge pclk);
    rd(A_RXL, {16'h0, v}, 1'b0);
    rd(A_RXR, {16'h0, ~v}, 1'b0);
    chk({31'h0, music_n}, {31'h0, exp_n}, "music flag");
    $display("test receive done");
  endtask : t_rx

  task automatic t_tx(input logic rate, input logic src, input logic [15:0] el, er);
    logic [31:0] l, r, nl, nr, p;
    logic [31:0] half;
    half = rate ? 32'h20 : 32'h18;
    rate_sel <= rate;
    src_sel <= src;
    xrun <= ~src;
    wr(A_TXL, {16'h0, el});
    wr(A_TXR, {16'h0, er});
    wr(A_CTRL, 32'h1);
    rd(A_STAT, {27'h0, src, 1'b1, rate, 2'b11}, 1'b0);
    grab(l, r, nl, nr, p);
    grab(l, r, nl, nr, p);
    chk(nl, half, "left bits");
    chk(nr, half, "right bits");
    chk(p, rate ? 32'h3C0 : 32'h500, "bit period");
    chk(l, {16'h0, el}, "left data");
    chk(r, {16'h0, er}, "right data");
    // Crystal stands still only on the external source, so feedback is steady
    if (src)
      chk({31'h0, xout}, {31'h0, ~xtal}, "crystal feedback");
    $display("test transmit done");
  endtask : t_tx

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_sel = 1'b0;
    align_sel = 1'b0;
    rate_sel = 1'b0;
    xrun = 1'b1;
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reg();
    t_rx(1'b0, 16'h4000, 1'b0);
    t_rx(1'b1, 16'h0010, 1'b1);
    t_tx(1'b0, 1'b0, 16'hA5C3, 16'h5A3C);
    t_tx(1'b1, 1'b0, 16'h8001, 16'h7FFE);
    t_tx(1'b1, 1'b1, 16'h1234, 16'hFEDC);
    end_of_test();
  end
endmodule : aspc_top_tb

`default_nettype wire
